// ---- hdl/cfaag_regs.svh ----
// Register offsets, reset values, vector limit and saturation values
`ifndef CFAAG_REGS_SVH
`define CFAAG_REGS_SVH
// Summary of operation
// - Stop-control bit 0 lets the halt instruction stop the clock; 1 makes it a no-op
// - Set mac overflow flag on overflow into accumulator sign bit 35
// - Set half-carry on carry out of bit 3 in byte BCD addition
// - Set extension overflow flag on overflow into accumulator bit 31
// - Negative follows result MSB; zero set when every result bit is zero
// - Set overflow flag on two's complement overflow
// - Carry records carry or borrow and links multiword shifts and rotates
// - Flags high byte S,MV,H,EV,N,Z,V,C; low byte mask, saturate, bank
// - Three-bit priority mask holds the current interrupt level, zero to seven
// - Saturate bit plus any overflow clamps the saturated accumulator read to signed extremes
// - Program bank field prefixes the program counter giving 20-bit fetch address
// - Bytes anywhere, words by low byte, fetches aligned, odd words split
// - Every mode makes 16 address bits, bank field adds four more
// - Bank crossing changes upper address bits but never the bank field; relative branches wrap the 16-bit counter inside the bank instead
// - Immediate address is byte after opcode; short immediates are sign-extended
// - Extended mode prefixes the extended bank field to the operand word
// - Indexed modes add unsigned 8-bit or signed 16-bit offset to index
// - Jump indexed mode adds a signed 20-bit offset to the index
// - Accumulator offset adds E to an index and leaves D untouched
// - Branches add signed offset to counter only when the condition holds
// - Moves use X as address first, then add signed 8-bit offset to X
// - First 512 bytes of page zero are vectors; Z loads from reset values
`define CFAAG_FLG_OFF    8'h00
`define CFAAG_XPTR_OFF   8'h04
`define CFAAG_YPTR_OFF   8'h08
`define CFAAG_ZPTR_OFF   8'h0c
`define CFAAG_PC_OFF     8'h10
`define CFAAG_ACC_OFF    8'h14
`define CFAAG_EXTB_OFF   8'h18
`define CFAAG_ALU_OFF    8'h1c
`define CFAAG_OPND_OFF   8'h20
`define CFAAG_AMLO_OFF   8'h24
`define CFAAG_AMHI_OFF   8'h28
`define CFAAG_AMSAT_OFF  8'h2c
`define CFAAG_EACMD_OFF  8'h30
`define CFAAG_EARES_OFF  8'h34
`define CFAAG_FLG_RST    16'h00e0
`define CFAAG_ZK_RST     4'h0
`define CFAAG_IZ_RST     16'h0000
`define CFAAG_VEC_LIMIT  20'h00200
`define CFAAG_SAT_POS    20'h07fff
`define CFAAG_SAT_NEG    20'hf8000
`endif

// ---- hdl/cfaag_pkg.sv ----
// Types shared by the flags and address generation block
package cfaag_pkg;
    typedef struct packed {
        logic       s;
        logic       mv;
        logic       h;
        logic       ev;
        logic       n;
        logic       z;
        logic       v;
        logic       c;
        logic [2:0] intm;
        logic       sm;
        logic [3:0] pk;
    } cfaag_flags_type;

    typedef enum logic [3:0] {
        OP_ADD   = 4'b0000,
        OP_ADC   = 4'b0001,
        OP_SUB   = 4'b0010,
        OP_BCD   = 4'b0011,
        OP_ROL   = 4'b0100,
        OP_ROR   = 4'b0101,
        OP_ADDI8 = 4'b0110,
        OP_MAC   = 4'b0111,
        OP_HALT  = 4'b1000
    } cfaag_op_type;

    typedef enum logic [2:0] {
        EA_IMM   = 3'b000,
        EA_EXT   = 3'b001,
        EA_IND8  = 3'b010,
        EA_IND16 = 3'b011,
        EA_IND20 = 3'b100,
        EA_ACC   = 3'b101,
        EA_REL   = 3'b110,
        EA_POST  = 3'b111
    } cfaag_mode_type;

    typedef struct packed {
        logic [19:0]    off;
        logic [2:0]     rsv;
        logic           lng;
        logic           cond;
        logic           word;
        logic [1:0]     sel;
        logic           rsv2;
        cfaag_mode_type mode;
    } cfaag_eacmd_type;
endpackage : cfaag_pkg

// ---- hdl/cfaag_top.sv ----
// Processor flags register and effective address generator behind APB
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "cfaag_regs.svh"
module cfaag_top
    import cfaag_pkg::*;
#(
    parameter logic [3:0]  ZK_RESET = `CFAAG_ZK_RST,
    parameter logic [15:0] IZ_RESET = `CFAAG_IZ_RST
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        wake_req,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             clk_stop,
    output logic [19:0]      fetch_addr
);
    // ==========================================================
    // State
    cfaag_flags_type flags_r;
    logic [19:0]     xptr_r;
    logic [19:0]     yptr_r;
    logic [19:0]     zptr_r;
    logic [15:0]     pc_r;
    logic [15:0]     d_r;
    logic [15:0]     e_r;
    logic [3:0]      ek_r;
    logic [15:0]     opnd_r;
    logic [35:0]     am_r;
    logic            am_sign_r;
    logic [19:0]     ea_r;
    logic            ea_split_r;
    logic            ea_vec_r;
    logic            pready_r;
    logic [31:0]     prdata_r;
    logic            pslverr_r;
    logic            clk_stop_r;
    logic [19:0]     fetch_r;

    // ==========================================================
    // APB decode
    wire        acc_ph   = psel & penable & ~pready_r;
    wire        done     = psel & penable & pready_r;
    wire        wr       = done & pwrite;
    wire        wr_flg   = wr & (paddr == `CFAAG_FLG_OFF);
    wire        wr_x     = wr & (paddr == `CFAAG_XPTR_OFF);
    wire        wr_y     = wr & (paddr == `CFAAG_YPTR_OFF);
    wire        wr_z     = wr & (paddr == `CFAAG_ZPTR_OFF);
    wire        wr_pc    = wr & (paddr == `CFAAG_PC_OFF);
    wire        wr_acc   = wr & (paddr == `CFAAG_ACC_OFF);
    wire        wr_ek    = wr & (paddr == `CFAAG_EXTB_OFF);
    wire        wr_alu   = wr & (paddr == `CFAAG_ALU_OFF);
    wire        wr_opnd  = wr & (paddr == `CFAAG_OPND_OFF);
    wire        wr_ea    = wr & (paddr == `CFAAG_EACMD_OFF);
    // Unaligned or unmapped offsets answer with pslverr and change nothing
    wire        mapped   = (paddr[1:0] == 2'b00) && (paddr <= `CFAAG_EARES_OFF);

    // ==========================================================
    // Arithmetic
    cfaag_op_type op;
    assign op = cfaag_op_type'(pwdata[3:0]);
    wire        bsel     = pwdata[4];
    wire [16:0] add_s    = {1'b0, d_r} + {1'b0, opnd_r}
                         + {16'h0000, (op == OP_ADC) & flags_r.c};
    wire [16:0] sub_s    = {1'b0, d_r} - {1'b0, opnd_r};
    wire [7:0]  bcd_a    = bsel ? d_r[7:0] : d_r[15:8];
    wire [8:0]  bcd_s    = {1'b0, bcd_a} + {1'b0, opnd_r[7:0]};
    wire [4:0]  bcd_lo   = {1'b0, bcd_a[3:0]} + {1'b0, opnd_r[3:0]};
    // Short immediate widened before the add
    wire [15:0] imm8_sx  = {{8{opnd_r[7]}}, opnd_r[7:0]};
    wire [15:0] ai_src   = bsel ? e_r : d_r;
    wire [16:0] ai_s     = {1'b0, ai_src} + {1'b0, imm8_sx};
    wire [31:0] prod     = $signed(d_r) * $signed(e_r);
    wire [35:0] mac_s    = am_r + {{4{prod[31]}}, prod};
    wire        mac_mv   = (am_r[35] == prod[31]) && (mac_s[35] != am_r[35]);
    wire        mac_ev   = ~((&mac_s[35:31]) | ~(|mac_s[35:31]));

    logic [15:0] res;
    logic        res_c;
    logic        res_v;
    logic        res_byte;
    always_comb begin
        res      = add_s[15:0];
        res_c    = add_s[16];
        res_v    = (d_r[15] == opnd_r[15]) && (add_s[15] != d_r[15]);
        res_byte = 1'b0;
        unique case (op)
            OP_SUB: begin
                res   = sub_s[15:0];
                res_c = sub_s[16];
                res_v = (d_r[15] != opnd_r[15]) && (sub_s[15] != d_r[15]);
            end
            OP_BCD: begin
                res      = {bcd_s[7:0], 8'h00};
                res_c    = bcd_s[8];
                res_v    = (bcd_a[7] == opnd_r[7]) && (bcd_s[7] != bcd_a[7]);
                res_byte = 1'b1;
            end
            OP_ROL: begin
                res   = {d_r[14:0], flags_r.c};
                res_c = d_r[15];
                res_v = d_r[15] ^ d_r[14];
            end
            OP_ROR: begin
                res   = {flags_r.c, d_r[15:1]};
                res_c = d_r[0];
                res_v = d_r[0] ^ flags_r.c;
            end
            OP_ADDI8: begin
                res   = ai_s[15:0];
                res_c = ai_s[16];
                res_v = (ai_src[15] == imm8_sx[15]) && (ai_s[15] != ai_src[15]);
            end
            default: begin
            end
        endcase
    end
    // Mac, halt and spare codes leave N, Z, V, C and H alone
    wire arith = wr_alu & (op <= OP_ADDI8);
    wire res_z = res_byte ? (res[15:8] == 8'h00) : (res == 16'h0000);

    // ==========================================================
    // Effective address
    cfaag_eacmd_type cmd;
    assign cmd = cfaag_eacmd_type'(pwdata);
    wire [19:0] base     = (cmd.sel == 2'd1) ? yptr_r :
                           (cmd.sel == 2'd2) ? zptr_r : xptr_r;
    wire [19:0] pc_full  = {flags_r.pk, pc_r};
    wire [19:0] rel_off  = cmd.lng ? {{4{cmd.off[15]}}, cmd.off[15:0]}
                                   : {{12{cmd.off[7]}}, cmd.off[7:0]};
    wire [15:0] pc_br    = pc_r + rel_off[15:0];
    logic [19:0] ea_nxt;
    always_comb begin
        // 20-bit sums let the upper bits move across a bank edge
        unique case (cmd.mode)
            EA_IMM:   ea_nxt = pc_full + (cmd.lng ? 20'h00002 : 20'h00001);
            EA_EXT:   ea_nxt = {ek_r, cmd.off[15:0]};
            EA_IND8:  ea_nxt = base + {12'h000, cmd.off[7:0]};
            EA_IND16: ea_nxt = base + {{4{cmd.off[15]}}, cmd.off[15:0]};
            EA_IND20: ea_nxt = base + cmd.off;
            EA_ACC:   ea_nxt = base + {{4{e_r[15]}}, e_r};
            EA_REL:   ea_nxt = cmd.cond ? {flags_r.pk, pc_br} : pc_full;
            EA_POST:  ea_nxt = xptr_r;
        endcase
    end
    // Odd word access goes out as two byte cycles
    wire split_nxt = cmd.word & ea_nxt[0];
    wire vec_nxt   = ea_nxt < `CFAAG_VEC_LIMIT;

    // ==========================================================
    // Saturated accumulator view
    wire        sat      = flags_r.sm & (flags_r.mv | flags_r.ev);
    wire [19:0] sat_val  = am_sign_r ? `CFAAG_SAT_NEG : `CFAAG_SAT_POS;
    wire [19:0] am_view  = sat ? sat_val : am_r[35:16];

    logic [31:0] rd_nxt;
    always_comb begin
        unique case (paddr)
            `CFAAG_FLG_OFF:   rd_nxt = {16'h0000, flags_r};
            `CFAAG_XPTR_OFF:  rd_nxt = {12'h000, xptr_r};
            `CFAAG_YPTR_OFF:  rd_nxt = {12'h000, yptr_r};
            `CFAAG_ZPTR_OFF:  rd_nxt = {12'h000, zptr_r};
            `CFAAG_PC_OFF:    rd_nxt = {16'h0000, pc_r};
            `CFAAG_ACC_OFF:   rd_nxt = {d_r, e_r};
            `CFAAG_EXTB_OFF:  rd_nxt = {28'h0000000, ek_r};
            `CFAAG_OPND_OFF:  rd_nxt = {16'h0000, opnd_r};
            `CFAAG_AMLO_OFF:  rd_nxt = am_r[31:0];
            `CFAAG_AMHI_OFF:  rd_nxt = {28'h0000000, am_r[35:32]};
            `CFAAG_AMSAT_OFF: rd_nxt = {12'h000, am_view};
            `CFAAG_EARES_OFF: rd_nxt = {10'h000, ea_vec_r, ea_split_r, ea_r};
            default:          rd_nxt = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Bus response
    // One wait state: pready rises after the first access edge
    wire [31:0] prdata_nxt  = acc_ph ? rd_nxt : 32'h00000000;
    wire        pslverr_nxt = acc_ph & ~mapped;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc_ph;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ==========================================================
    // Flags register
    cfaag_flags_type flags_nxt;
    logic            sign_nxt;
    wire             mac_wr    = wr_alu & (op == OP_MAC);
    // Sign is frozen at the first overflow so the clamp keeps its direction
    wire             mac_first = ~(flags_r.mv | flags_r.ev) & (mac_mv | mac_ev);
    always_comb begin
        flags_nxt = flags_r;
        sign_nxt  = am_sign_r;
        if (wr_flg) begin
            flags_nxt = cfaag_flags_type'(pwdata[15:0]);
        end else if (mac_wr) begin
            flags_nxt.mv = flags_r.mv | mac_mv;
            flags_nxt.ev = flags_r.ev | mac_ev;
            if (mac_first)
                sign_nxt = am_r[35];
        end else if (arith) begin
            flags_nxt.n = res[15];
            flags_nxt.z = res_z;
            flags_nxt.v = res_v;
            flags_nxt.c = res_c;
            if (op == OP_BCD)
                flags_nxt.h = bcd_lo[4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r   <= cfaag_flags_type'(`CFAAG_FLG_RST);
            am_sign_r <= 1'b0;
        end else begin
            flags_r   <= flags_nxt;
            am_sign_r <= sign_nxt;
        end
    end

    // ==========================================================
    // Data and address registers
    // Post-modify moves only the index half, so the bank stays put
    wire [15:0] xidx_post = xptr_r[15:0] + {{8{cmd.off[7]}}, cmd.off[7:0]};
    wire        x_post    = wr_ea & (cmd.mode == EA_POST);
    wire        pc_take   = wr_ea & (cmd.mode == EA_REL) & cmd.cond;
    wire        bcd_wr    = arith & (op == OP_BCD);
    wire        e_imm_wr  = arith & (op == OP_ADDI8) & bsel;
    logic [19:0] xptr_nxt;
    logic [15:0] pc_nxt;
    logic [15:0] d_nxt;
    logic [15:0] e_nxt;
    assign xptr_nxt = wr_x   ? pwdata[19:0] :
                      x_post ? {xptr_r[19:16], xidx_post} : xptr_r;
    assign pc_nxt   = wr_pc   ? pwdata[15:0] :
                      pc_take ? pc_br : pc_r;
    always_comb begin
        d_nxt = d_r;
        e_nxt = e_r;
        if (wr_acc) begin
            d_nxt = pwdata[31:16];
            e_nxt = pwdata[15:0];
        end else if (bcd_wr & bsel) begin
            d_nxt[7:0] = res[15:8];
        end else if (bcd_wr) begin
            d_nxt[15:8] = res[15:8];
        end else if (e_imm_wr) begin
            e_nxt = res;
        end else if (arith) begin
            d_nxt = res;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xptr_r <= 20'h00000;
            yptr_r <= 20'h00000;
            zptr_r <= {ZK_RESET, IZ_RESET};
        end else begin
            xptr_r <= xptr_nxt;
            if (wr_y)
                yptr_r <= pwdata[19:0];
            if (wr_z)
                zptr_r <= pwdata[19:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= 16'h0000;
            d_r  <= 16'h0000;
            e_r  <= 16'h0000;
        end else begin
            pc_r <= pc_nxt;
            d_r  <= d_nxt;
            e_r  <= e_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ek_r   <= 4'h0;
            opnd_r <= 16'h0000;
            am_r   <= 36'h000000000;
        end else begin
            if (wr_ek)
                ek_r <= pwdata[3:0];
            if (wr_opnd)
                opnd_r <= pwdata[15:0];
            if (mac_wr)
                am_r <= mac_s;
        end
    end

    // ==========================================================
    // Address result, halt and fetch
    // Halt request wins over a wake in the same cycle
    wire        halt_take = wr_alu & (op == OP_HALT) & ~flags_r.s;
    wire        stop_nxt  = halt_take | (clk_stop_r & ~wake_req);
    // Fetch drops the low counter bit so it stays word aligned
    wire [19:0] fetch_nxt = {pc_full[19:1], 1'b0};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea_r       <= 20'h00000;
            ea_split_r <= 1'b0;
            ea_vec_r   <= 1'b0;
        end else if (wr_ea) begin
            ea_r       <= ea_nxt;
            ea_split_r <= split_nxt;
            ea_vec_r   <= vec_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_stop_r <= 1'b0;
            fetch_r    <= 20'h00000;
        end else begin
            clk_stop_r <= stop_nxt;
            fetch_r    <= fetch_nxt;
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign clk_stop   = clk_stop_r;
    assign fetch_addr = fetch_r;
endmodule : cfaag_top

// ---- sim/cfaag_monitor.sv ----
// Port checker for the flags and address generation block
`timescale 1ns/1ps
`include "cfaag_regs.svh"
module cfaag_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        wake_req,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        clk_stop,
    input wire logic [19:0] fetch_addr
);
    // ==========
    // Helpers
    wire logic done_w = psel && penable && pready;
    wire logic halt_w = done_w && pwrite && paddr == `CFAAG_ALU_OFF && pwdata[3:0] == 4'h8;
    wire logic pcw_w  = done_w && pwrite && paddr == `CFAAG_PC_OFF;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========
    // Assertions
    property p_one_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access answered late");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready held too long");
    property p_cause;
        pready |-> $past(psel && penable);
    endproperty
    a_cause: assert property (p_cause) else $error("pready without access");
    property p_err_pair;
        pslverr |-> pready;
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
    property p_idle_data;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("prdata outside answer");
    property p_unaligned;
        done_w && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned access accepted");
    property p_fetch_align;
        fetch_addr[0] == 1'b0;
    endproperty
    a_fetch_align: assert property (p_fetch_align) else $error("odd fetch address");
    property p_stop_cause;
        $rose(clk_stop) |-> $past(halt_w);
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stop without halt");
    property p_wake;
        clk_stop && wake_req && !halt_w |=> !clk_stop;
    endproperty
    a_wake: assert property (p_wake) else $error("wake ignored");
    property p_pc_fetch;
        pcw_w |-> ##2 fetch_addr[15:1] == $past(pwdata[15:1], 2);
    endproperty
    a_pc_fetch: assert property (p_pc_fetch) else $error("fetch lags counter");
endmodule : cfaag_monitor

bind cfaag_top cfaag_monitor u_cfaag_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .wake_req(wake_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_stop(clk_stop), .fetch_addr(fetch_addr)
);

// ---- sim/tb_cfaag_top.sv ----
// Self-checking bench for the flags and address generation block
`timescale 1ns/1ps
`include "cfaag_regs.svh"
module tb_cfaag_top;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic        wake_req = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clk_stop;
    logic [19:0] fetch_addr;
    logic [31:0] rd;
    logic        err;
    int          failures        = 0;
    int          samples_checked = 0;

    cfaag_top #(.ZK_RESET(4'h0), .IZ_RESET(16'h0100)) u_cfaag_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .wake_req(wake_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_stop(clk_stop), .fetch_addr(fetch_addr)
    );

    always #4 pclk = ~pclk;

    // ==========
    // Common tasks
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Idle cycle after each transfer keeps every strobe to one change per step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // ==========
    // Scenarios
    task automatic t_reset;
        rdchk(`CFAAG_FLG_OFF, 32'h0000_00e0);
        chk({31'h0, err}, 32'h0);
        rdchk(`CFAAG_ZPTR_OFF, 32'h0000_0100);
        rdchk(8'h38, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(8'h02, 32'h1);
        chk({31'h0, err}, 32'h1);
    endtask : t_reset

    task automatic t_flags;
        for (int i = 0; i < 8; i++) begin
            wr(`CFAAG_FLG_OFF, {16'h0, 8'hff, 3'(i), 5'h1f});
            rdchk(`CFAAG_FLG_OFF, {16'h0, 8'hff, 3'(i), 5'h1f});
        end
    endtask : t_flags

    task automatic alu(input logic [4:0] cmd, input logic [15:0] d, opnd, pre, expd,
                       input logic [15:0] expf, mask);
        wr(`CFAAG_FLG_OFF, {16'h0, pre});
        wr(`CFAAG_ACC_OFF, {d, 16'h0003});
        wr(`CFAAG_OPND_OFF, {16'h0, opnd});
        wr(`CFAAG_ALU_OFF, {27'h0, cmd});
        rdchk(`CFAAG_ACC_OFF, {expd, 16'h0003});
        xfer(1'b0, `CFAAG_FLG_OFF, 32'h0);
        chk(rd & {16'h0, mask}, {16'h0, expf});
    endtask : alu

    task automatic t_alu;
        alu(5'h00, 16'h7fff, 16'h0001, 16'h00e0, 16'h8000, 16'h0a00, 16'h0f00);
        alu(5'h00, 16'hffff, 16'h0001, 16'h00e0, 16'h0000, 16'h0500, 16'h0f00);
        alu(5'h01, 16'h0001, 16'h0001, 16'h01e0, 16'h0003, 16'h0000, 16'h0f00);
        alu(5'h02, 16'h0000, 16'h0001, 16'h00e0, 16'hffff, 16'h0900, 16'h0f00);
        alu(5'h04, 16'h8000, 16'h0000, 16'h00e0, 16'h0000, 16'h0100, 16'h0100);
        alu(5'h05, 16'h0001, 16'h0000, 16'h01e0, 16'h8000, 16'h0100, 16'h0100);
        alu(5'h06, 16'h0010, 16'h00f0, 16'h00e0, 16'h0000, 16'h0000, 16'h0000);
        alu(5'h03, 16'h0900, 16'h0008, 16'h00e0, 16'h1100, 16'h2000, 16'h2f00);
        alu(5'h13, 16'h0009, 16'h0008, 16'h00e0, 16'h0011, 16'h2000, 16'h2f00);
        wr(`CFAAG_ACC_OFF, 32'h0000_0003);
        wr(`CFAAG_OPND_OFF, 32'h00fe);
        wr(`CFAAG_ALU_OFF, 32'h16);
        rdchk(`CFAAG_ACC_OFF, 32'h0000_0001);
    endtask : t_alu

    task automatic t_mac;
        wr(`CFAAG_FLG_OFF, 32'h00e0);
        wr(`CFAAG_ACC_OFF, 32'h8000_8000);
        for (int i = 0; i < 32; i++) begin
            wr(`CFAAG_ALU_OFF, 32'h7);
            if (i == 1) begin
                xfer(1'b0, `CFAAG_FLG_OFF, 32'h0);
                chk(rd & 32'h5000, 32'h1000);
            end
        end
        xfer(1'b0, `CFAAG_FLG_OFF, 32'h0);
        chk(rd & 32'h4000, 32'h4000);
        rdchk(`CFAAG_AMHI_OFF, 32'h8);
        rdchk(`CFAAG_AMSAT_OFF, 32'h80000);
        wr(`CFAAG_FLG_OFF, 32'h50f0);
        rdchk(`CFAAG_AMSAT_OFF, {12'h0, `CFAAG_SAT_POS});
    endtask : t_mac

    task automatic eachk(input logic [31:0] cmd, input logic [21:0] exp);
        wr(`CFAAG_EACMD_OFF, cmd);
        rdchk(`CFAAG_EARES_OFF, {10'h0, exp});
    endtask : eachk

    task automatic t_ea;
        wr(`CFAAG_XPTR_OFF, 32'h2fff0);
        wr(`CFAAG_EXTB_OFF, 32'h5);
        wr(`CFAAG_ACC_OFF, 32'h1234_0020);
        wr(`CFAAG_FLG_OFF, 32'h00e3);
        wr(`CFAAG_PC_OFF, 32'h1000);
        eachk({20'h00020, 12'h002}, 22'h030010);
        rdchk(`CFAAG_XPTR_OFF, 32'h2fff0);
        wr(`CFAAG_YPTR_OFF, 32'h4fffe);
        eachk({20'h00004, 12'h012}, 22'h050002);
        eachk({20'h00021, 12'h042}, 22'h130011);
        eachk({20'h0fff0, 12'h003}, 22'h02ffe0);
        eachk({20'hfffff, 12'h004}, 22'h02ffef);
        eachk({20'h01234, 12'h001}, 22'h051234);
        eachk({20'h00000, 12'h005}, 22'h030010);
        rdchk(`CFAAG_ACC_OFF, 32'h1234_0020);
        eachk({20'h00000, 12'h000}, 22'h031001);
        eachk({20'h00000, 12'h100}, 22'h031002);
        wr(`CFAAG_EACMD_OFF, {20'h000fe, 12'h006});
        rdchk(`CFAAG_PC_OFF, 32'h1000);
        eachk({20'h000fe, 12'h086}, 22'h030ffe);
        rdchk(`CFAAG_PC_OFF, 32'h0ffe);
        chk({12'h0, fetch_addr}, 32'h30ffe);
        eachk({20'h00080, 12'h007}, 22'h02fff0);
        rdchk(`CFAAG_XPTR_OFF, 32'h2ff70);
        eachk({20'h00010, 12'h022}, 22'h200110);
        wr(`CFAAG_PC_OFF, 32'h1001);
        rdchk(`CFAAG_PC_OFF, 32'h1001);
        chk({12'h0, fetch_addr}, 32'h31000);
    endtask : t_ea

    task automatic t_halt;
        wr(`CFAAG_FLG_OFF, 32'h00e0);
        wr(`CFAAG_ALU_OFF, 32'h8);
        chk({31'h0, clk_stop}, 32'h1);
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, clk_stop}, 32'h0);
        wr(`CFAAG_FLG_OFF, 32'h80e0);
        wr(`CFAAG_ALU_OFF, 32'h8);
        chk({31'h0, clk_stop}, 32'h0);
    endtask : t_halt

    // ==========
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_flags();
        t_alu();
        t_mac();
        t_ea();
        t_halt();
        stop_test();
    end

    // Whole run needs fewer than a thousand cycles
    initial begin
        #100000;
        failures++;
        stop_test();
    end
endmodule : tb_cfaag_top
